// [design/dwc_regs.svh]
`ifndef DWC_REGS_SVH
`define DWC_REGS_SVH

// Register byte offsets on the bus
`define DWC_OFF_DATA    8'h00
`define DWC_OFF_FEAT    8'h04
`define DWC_OFF_CNT     8'h08
`define DWC_OFF_ADR0    8'h0C
`define DWC_OFF_ADR1    8'h10
`define DWC_OFF_ADR2    8'h14
`define DWC_OFF_DEVH    8'h18
`define DWC_OFF_CMD     8'h1C
`define DWC_OFF_ERR     8'h20
`define DWC_OFF_STAT    8'h24
`define DWC_OFF_IRQ_STS 8'h28
`define DWC_OFF_IRQ_CLR 8'h2C
`define DWC_OFF_IRQ_EN  8'h30

// Command opcodes
`define DWC_OP_WBUF     8'hE8
`define DWC_OP_WBUF_DMA 8'hEB
`define DWC_OP_WDMA     8'hCA

// Field positions
`define DWC_STAT_BSY  7
`define DWC_STAT_RDY  6
`define DWC_STAT_DSC  4
`define DWC_STAT_DRQ  3
`define DWC_STAT_ERR  0
`define DWC_ERR_CRC   7
`define DWC_ERR_IDN   4
`define DWC_ERR_ABT   2
`define DWC_DEVH_LBA  6
`define DWC_IRQ_DONE  0
`define DWC_IRQ_FAIL  1

// Reset values and counts
`define DWC_DEVH_RST  8'hA0
`define DWC_SECT_WORDS 256
`define DWC_MAX_SECTS  256
`endif

// [design/dwc_pkg.sv]
package dwc_pkg;
	// Command sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PIO,
		ST_DBUF,
		ST_DXFER,
		ST_MREQ,
		ST_FIN
	} dwc_state_e;
	// Byte and word types
	typedef logic [7:0]  dwc_byte_t;
	typedef logic [15:0] dwc_word_t;
endpackage : dwc_pkg

// [design/dwc_sbuf_if.sv]
`timescale 1ns/10ps
// Sector buffer port between sequencer and memory
interface dwc_sbuf_if #(parameter int AW = 8);
	logic          wr_en;   // Write strobe
	logic [AW-1:0] wr_addr; // Write word index
	logic [15:0]   wr_data; // Write word
	logic [AW-1:0] rd_addr; // Read word index
	logic [15:0]   rd_data; // Registered read word
	modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
	modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
endinterface : dwc_sbuf_if

// [design/dwc_sbuf_mem.sv]
`timescale 1ns/10ps
// Single sector buffer, one write and one registered read port
module dwc_sbuf_mem #(
	parameter int DEPTH = 256
) (
	input  wire logic mclk,
	dwc_sbuf_if.mem   sb
);
	logic [15:0] mem_q [DEPTH]; // Storage, no reset needed
	logic [15:0] rd_q;          // Read data register

	//////////////////////////////////////////////////////////////
	// Write and read, read data lags the address by one edge
	always_ff @(posedge mclk) begin
		if (sb.wr_en) begin
			mem_q[sb.wr_addr] <= sb.wr_data;
		end
		rd_q <= mem_q[sb.rd_addr];
	end

	assign sb.rd_data = rd_q;
endmodule : dwc_sbuf_mem

// [design/dwc_write_cmd.sv]
`timescale 1ns/10ps
`include "dwc_regs.svh"
// Write command handler: buffer writes and DMA media writes
module dwc_write_cmd import dwc_pkg::*; #(
	parameter int WORDS = `DWC_SECT_WORDS
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq,
	output logic             dmarq,
	input  wire logic        dmack,
	input  wire logic [15:0] dma_wdata,
	input  wire logic        dma_crc_err,
	output logic             media_req,
	output logic      [27:0] media_addr,
	output logic             media_lba,
	input  wire logic [7:0]  media_word_idx,
	output logic      [15:0] media_word,
	input  wire logic        media_done,
	input  wire logic        media_unc,
	input  wire logic        media_idnf
);
	localparam int AW = $clog2(WORDS);

	dwc_sbuf_if #(.AW(AW)) sb ();   // Buffer port
	dwc_sbuf_mem #(.DEPTH(WORDS)) u_mem (
		.mclk (mclk),
		.sb   (sb)
	);

	//////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [8:0] sect_total(input dwc_byte_t c);
		return (c == 8'h00) ? 9'h100 : {1'b0, c};
	endfunction : sect_total

	//////////////////////////////////////////////////////////////
	// Bus address phase capture
	logic       dp_wr_q, dp_rd_q;  // Data phase pending
	logic [7:0] dp_addr_q;         // Captured byte offset
	wire        ap_take = hsel & htrans[1] & hready;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dp_wr_q   <= 1'b0;
			dp_rd_q   <= 1'b0;
			dp_addr_q <= 8'h00;
		end else begin
			dp_wr_q   <= ap_take & hwrite;
			dp_rd_q   <= ap_take & ~hwrite;
			dp_addr_q <= ap_take ? haddr[7:0] : dp_addr_q;
		end
	end

	// Single-cycle slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	//////////////////////////////////////////////////////////////
	// State and working registers
	dwc_state_e state_q;
	dwc_byte_t  feat_q, cnt_q, adr0_q, adr1_q, adr2_q, devh_q;
	dwc_byte_t  err_q;          // Error register
	logic       drq_q;          // PIO data request
	logic       errst_q;        // Ending error status
	logic       media_cmd_q;    // Running media write
	logic [AW-1:0] wptr_q;      // Buffer write index
	logic [AW-1:0] rptr_q;      // Buffer read index
	logic [8:0] remain_q;       // Sectors not yet written
	logic [27:0] cur_q;         // Current sector address
	logic [1:0] irq_sts_q, irq_en_q;

	// Write and read decode
	wire wr_cmd  = dp_wr_q && dp_addr_q == `DWC_OFF_CMD;
	wire wr_data = dp_wr_q && dp_addr_q == `DWC_OFF_DATA;
	wire rd_data = dp_rd_q && dp_addr_q == `DWC_OFF_DATA;
	wire wr_clr  = dp_wr_q && dp_addr_q == `DWC_OFF_IRQ_CLR;
	wire idle    = state_q == ST_IDLE;
	wire [7:0] opc = hwdata[7:0];

	// Opcode decode, low bit of media write is retry, don't care
	wire op_wbuf  = opc == `DWC_OP_WBUF;
	wire op_wbufd = opc == `DWC_OP_WBUF_DMA;
	wire op_wdma  = opc[7:1] == `DWC_OP_WDMA >> 1;
	wire cmd_go   = wr_cmd & idle;

	// DMA word acceptance: only while request is up
	wire dma_st   = state_q == ST_DBUF || state_q == ST_DXFER;
	assign dmarq  = dma_st;
	wire dma_word = dmarq & dmack;
	wire pio_word = wr_data & (state_q == ST_PIO);
	wire buf_word = dma_word | pio_word;
	wire last_wd  = wptr_q == AW'(WORDS - 1);

	// Buffer port, 16-bit words only
	assign sb.wr_en   = buf_word;
	assign sb.wr_addr = wptr_q;
	assign sb.wr_data = dma_word ? dma_wdata : hwdata[15:0];
	assign sb.rd_addr = (state_q == ST_MREQ) ? media_word_idx[AW-1:0] : rptr_q;
	assign media_word = sb.rd_data;

	// Media side
	assign media_req  = state_q == ST_MREQ;
	assign media_addr = cur_q;
	assign media_lba  = devh_q[`DWC_DEVH_LBA];
	wire   med_fail   = media_done & (media_unc | media_idnf) & media_req;
	wire   med_ok     = media_done & ~(media_unc | media_idnf) & media_req;

	// Next address: linear in block mode, sector byte only in geometry mode
	wire [27:0] cur_inc = media_lba ? cur_q + 28'h0000001
	                                : {cur_q[27:8], cur_q[7:0] + 8'h01};

	//////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (cmd_go) begin
						if (op_wbuf) state_q <= ST_PIO;
						else if (op_wbufd) state_q <= ST_DBUF;
						else if (op_wdma) state_q <= ST_DXFER;
						else state_q <= ST_FIN;
					end
				end
				ST_PIO, ST_DBUF: begin
					if (dma_crc_err && state_q == ST_DBUF) state_q <= ST_FIN;
					else if (buf_word && last_wd) state_q <= ST_FIN;
				end
				ST_DXFER: begin
					if (dma_crc_err) state_q <= ST_FIN;
					else if (dma_word && last_wd) state_q <= ST_MREQ;
				end
				ST_MREQ: begin
					if (med_fail) state_q <= ST_FIN;
					else if (med_ok) state_q <= (remain_q == 9'h001) ? ST_FIN : ST_DXFER;
				end
				ST_FIN: state_q <= ST_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////
	// Buffer pointers, both rewound by any buffer command
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			if (cmd_go) wptr_q <= '0;
			else if (med_ok) wptr_q <= '0;
			else if (buf_word) wptr_q <= wptr_q + AW'(1);
			if (cmd_go && (op_wbuf || op_wbufd)) rptr_q <= '0;
			else if (rd_data && idle) rptr_q <= rptr_q + AW'(1);
		end
	end

	//////////////////////////////////////////////////////////////
	// Sector count and address tracking of the media write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			remain_q    <= 9'h000;
			cur_q       <= 28'h0000000;
			media_cmd_q <= 1'b0;
		end else begin
			if (cmd_go) begin
				media_cmd_q <= op_wdma;
				remain_q    <= sect_total(cnt_q);
				// Head nibble and three bytes form the start address
				cur_q <= {devh_q[3:0], adr2_q, adr1_q, adr0_q};
			end else if (med_ok) begin
				remain_q <= remain_q - 9'h001;
				// Stay on the last sector when nothing remains
				if (remain_q != 9'h001) cur_q <= cur_inc;
			end
		end
	end

	//////////////////////////////////////////////////////////////
	// Command block registers: host writes while idle, device
	// loads ending values at the end of a media write
	wire fin_media = state_q == ST_FIN && media_cmd_q;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			feat_q <= 8'h00;
			cnt_q  <= 8'h00;
			adr0_q <= 8'h00;
			adr1_q <= 8'h00;
			adr2_q <= 8'h00;
			devh_q <= `DWC_DEVH_RST;
		end else if (fin_media) begin
			cnt_q  <= remain_q[7:0];
			adr0_q <= cur_q[7:0];
			adr1_q <= cur_q[15:8];
			adr2_q <= cur_q[23:16];
			devh_q <= {devh_q[7:4], cur_q[27:24]};
		end else if (dp_wr_q && idle) begin
			// Writes while busy are dropped
			if (dp_addr_q == `DWC_OFF_FEAT) feat_q <= hwdata[7:0];
			if (dp_addr_q == `DWC_OFF_CNT)  cnt_q  <= hwdata[7:0];
			if (dp_addr_q == `DWC_OFF_ADR0) adr0_q <= hwdata[7:0];
			if (dp_addr_q == `DWC_OFF_ADR1) adr1_q <= hwdata[7:0];
			if (dp_addr_q == `DWC_OFF_ADR2) adr2_q <= hwdata[7:0];
			if (dp_addr_q == `DWC_OFF_DEVH) devh_q <= hwdata[7:0];
		end
	end

	//////////////////////////////////////////////////////////////
	// Error register and ending status
	wire bad_op = cmd_go & ~(op_wbuf | op_wbufd | op_wdma);
	wire crc_hit = dma_crc_err & dma_st;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			err_q   <= 8'h00;
			errst_q <= 1'b0;
			drq_q   <= 1'b0;
		end else begin
			if (cmd_go) err_q <= 8'h00;
			if (bad_op) err_q[`DWC_ERR_ABT] <= 1'b1;
			if (crc_hit) err_q[`DWC_ERR_CRC] <= 1'b1;
			// Unreadable media aborts; a missing address reports IDN alone, not abort
			if (med_fail) err_q[`DWC_ERR_ABT] <= media_unc;
			if (med_fail) err_q[`DWC_ERR_IDN] <= media_idnf;
			if (cmd_go) errst_q <= 1'b0;
			else if (state_q == ST_FIN)
				errst_q <= err_q[`DWC_ERR_ABT] | err_q[`DWC_ERR_IDN] | err_q[`DWC_ERR_CRC];
			drq_q <= (cmd_go && op_wbuf) || (drq_q && !(pio_word && last_wd));
		end
	end

	// PIO phase shows data request with busy low
	wire busy = !idle && !(state_q == ST_PIO);
	wire [7:0] stat = {busy, !busy && idle, 1'b0, 1'b1, drq_q, 2'b00, errst_q};

	//////////////////////////////////////////////////////////////
	// Interrupt: one event per command, set wins over clear
	wire       ev_fin = state_q == ST_FIN;
	wire [1:0] ev_set = {ev_fin & (|err_q), ev_fin};
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq_sts_q <= 2'b00;
			irq_en_q  <= 2'b00;
		end else begin
			irq_sts_q <= (irq_sts_q & ~(wr_clr ? hwdata[1:0] : 2'b00)) | ev_set;
			if (dp_wr_q && dp_addr_q == `DWC_OFF_IRQ_EN) irq_en_q <= hwdata[1:0];
		end
	end
	assign irq = |(irq_sts_q & irq_en_q);

	//////////////////////////////////////////////////////////////
	// Read data, selected in the data phase from registers
	logic [7:0] rsel;
	always_comb begin
		unique case (dp_addr_q)
			`DWC_OFF_FEAT:    rsel = 8'h00;
			`DWC_OFF_CNT:     rsel = cnt_q;
			`DWC_OFF_ADR0:    rsel = adr0_q;
			`DWC_OFF_ADR1:    rsel = adr1_q;
			`DWC_OFF_ADR2:    rsel = adr2_q;
			`DWC_OFF_DEVH:    rsel = devh_q;
			`DWC_OFF_ERR:     rsel = err_q;
			`DWC_OFF_STAT:    rsel = stat;
			`DWC_OFF_IRQ_STS: rsel = {6'h00, irq_sts_q};
			`DWC_OFF_IRQ_EN:  rsel = {6'h00, irq_en_q};
			default:          rsel = 8'h00;
		endcase
	end
	// Data word comes straight from the buffer register
	assign hrdata = !dp_rd_q ? 32'h0000_0000 :
	                (dp_addr_q == `DWC_OFF_DATA) ? {16'h0000, sb.rd_data} :
	                {24'h00_0000, rsel};

	//////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_pio_start;
		cmd_go && op_wbuf |=> state_q == ST_PIO && wptr_q == '0 && drq_q;
	endproperty
	a_pio_start: assert property (p_pio_start) else $error("PIO write did not start");

	property p_dbuf_start;
		cmd_go && op_wbufd |=> state_q == ST_DBUF && dmarq;
	endproperty
	a_dbuf_start: assert property (p_dbuf_start) else $error("DMA buffer write did not start");

	property p_wdma_start;
		cmd_go && opc[7:1] == 7'h65 |=> state_q == ST_DXFER && media_cmd_q;
	endproperty
	a_wdma_start: assert property (p_wdma_start) else $error("Media write not taken");

	property p_count;
		cmd_go && op_wdma |=> remain_q == (($past(cnt_q) == 8'h00) ? 9'h100 : {1'b0, $past(cnt_q)});
	endproperty
	a_count: assert property (p_count) else $error("Sector total wrong");

	property p_dma_qual;
		sb.wr_en && dma_st |-> dmarq && dmack;
	endproperty
	a_dma_qual: assert property (p_dma_qual) else $error("DMA word without request");

	property p_one_irq;
		$rose(irq_sts_q[`DWC_IRQ_DONE]) |-> $past(state_q) == ST_FIN && idle;
	endproperty
	a_one_irq: assert property (p_one_irq) else $error("Interrupt not at command end");

	property p_stop;
		med_fail |=> state_q == ST_FIN ##1 idle;
	endproperty
	a_stop: assert property (p_stop) else $error("Write went past failing sector");

	property p_remain_zero;
		fin_media && remain_q == 9'h000 |=> cnt_q == 8'h00 && !errst_q;
	endproperty
	a_remain_zero: assert property (p_remain_zero) else $error("Count not zero on success");

	property p_abort_err;
		bad_op |=> ##1 stat[`DWC_STAT_ERR] && !stat[`DWC_STAT_BSY] && stat[`DWC_STAT_RDY];
	endproperty
	a_abort_err: assert property (p_abort_err) else $error("Abort not reported");

	// CRC fault ends a DMA phase at once with the fault recorded
	property p_crc_end;
		crc_hit |=> state_q == ST_FIN && err_q[`DWC_ERR_CRC];
	endproperty
	a_crc_end: assert property (p_crc_end) else $error("CRC fault did not end command");

	// Host writes cost about three cycles a word, so a full load needs the long window
	c_pio:  cover property (state_q == ST_PIO ##[1:1000] state_q == ST_FIN);
	c_dma2: cover property (med_ok && remain_q == 9'h002 ##[1:900] fin_media);
	c_fail: cover property (med_fail);
	c_bad:  cover property (bad_op);
	c_crc:  cover property (crc_hit);
endmodule : dwc_write_cmd

// [tb/dwc_host_model.sv]
`timescale 1ns/10ps
// Host slave-DMA channel and media stand-in
module dwc_host_model (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        dmarq,
	output logic             dmack,
	output logic      [15:0] dma_wdata,
	input  wire logic        media_req,
	input  wire logic [27:0] media_addr,
	input  wire logic        media_lba,
	output logic      [7:0]  media_word_idx,
	input  wire logic [15:0] media_word,
	output logic             media_done,
	output logic             media_unc,
	output logic             media_idnf,
	input  wire logic        idnf_sel,
	input  wire logic [15:0] unc_at,
	output logic      [15:0] sect_cnt,
	output logic      [28:0] last_addr,
	output logic      [15:0] bad_cnt
);
	logic [15:0] wcnt;  // Words taken so far
	logic [2:0]  tick;  // Stall pacing
	logic [2:0]  mstep; // Media read step
	logic [7:0]  pidx;  // Index asked one step back
	////////////////////////////////////////////////////////////////
	// Outside a taken word the bus shows the inverse, not stale data
	assign dma_wdata = dmack ? {wcnt[7:0], ~wcnt[7:0]} : ~{wcnt[7:0], ~wcnt[7:0]};
	assign media_word_idx = {5'h0, mstep} * 8'h55;
	assign pidx = {5'h0, mstep - 3'h1} * 8'h55;
	// Channel set up from reset; answers only a raised request, stalls one cycle in eight
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tick  <= 3'h0;
			dmack <= 1'b0;
			wcnt  <= 16'h0;
		end else begin
			tick  <= tick + 3'h1;
			dmack <= dmarq && (tick != 3'h0);
			if (dmarq && dmack) begin
				wcnt <= wcnt + 16'h1;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Media reads four words, checks them, then ends the step
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mstep      <= 3'h0;
			media_done <= 1'b0;
			media_unc  <= 1'b0;
			media_idnf <= 1'b0;
			sect_cnt   <= 16'h0;
			last_addr  <= 29'h0;
			bad_cnt    <= 16'h0;
		end else begin
			media_done <= 1'b0;
			media_unc  <= 1'b0;
			media_idnf <= 1'b0;
			if (!media_req) begin
				mstep <= 3'h0;
			end else if (!media_done) begin
				// Word lands one cycle after its index
				if (mstep != 3'h0 && media_word !== {pidx, ~pidx}) begin
					bad_cnt <= bad_cnt + 16'h1;
				end
				mstep <= mstep + 3'h1;
				if (mstep == 3'h4) begin
					mstep      <= 3'h0;
					media_done <= 1'b1;
					// The chosen sector fails as unreadable or as an unknown address
					media_unc  <= (sect_cnt == unc_at) && !idnf_sel;
					media_idnf <= (sect_cnt == unc_at) && idnf_sel;
					sect_cnt   <= sect_cnt + 16'h1;
					last_addr  <= {media_lba, media_addr};
				end
			end
		end
	end
endmodule : dwc_host_model

// [tb/disk_write_command_handler_test.sv]
`timescale 1ns/10ps
`include "dwc_regs.svh"
// Bench for the write command handler
module disk_write_command_handler_test;
	logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, irq, dmarq, dmack;
	logic        media_req, media_lba, media_done, media_unc;
	logic        media_idnf, idnf_sel, crc_err;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] dma_wdata, media_word, unc_at, sect_cnt, bad_cnt, s0;
	logic [7:0]  media_word_idx;
	logic [27:0] media_addr;
	logic [28:0] last_addr;
	int          fail_count, num_checks, cyc, i;
	////////////////////////////////////////////////////////////////
	dwc_write_cmd DUT (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq), .dmarq(dmarq), .dmack(dmack),
		.dma_wdata(dma_wdata), .dma_crc_err(crc_err), .media_req(media_req), .media_addr(media_addr),
		.media_lba(media_lba), .media_word_idx(media_word_idx), .media_word(media_word),
		.media_done(media_done), .media_unc(media_unc), .media_idnf(media_idnf));
	dwc_host_model HOST (.mclk(mclk), .rst_n(rst_n), .dmarq(dmarq), .dmack(dmack), .dma_wdata(dma_wdata),
		.media_req(media_req), .media_addr(media_addr), .media_lba(media_lba),
		.media_word_idx(media_word_idx), .media_word(media_word), .media_done(media_done),
		.media_unc(media_unc), .media_idnf(media_idnf), .idnf_sel(idnf_sel),
		.unc_at(unc_at), .sect_cnt(sect_cnt), .last_addr(last_addr),
		.bad_cnt(bad_cnt));
	////////////////////////////////////////////////////////////////
	initial mclk = 1'b0;
	always #50 mclk = ~mclk;
	// Hang guard, far above the few thousand cycles needed
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	// One single-word transfer; read data lands in r
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		r = hrdata;
	endtask : bus
	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, r & m, e);
	endtask : rchk
	// Polls status until an event shows, bounded
	task wait_irq;
		int k;
		r = 32'h0;
		for (k = 0; k < 3000 && r[1:0] == 2'b00; k++) bus(1'b0, `DWC_OFF_IRQ_STS, 32'h0);
	endtask : wait_irq
	// Whole buffer back through the data port; inv picks the PIO pattern
	task rb(input logic inv);
		for (i = 0; i < 256; i++) begin
			bus(1'b0, `DWC_OFF_DATA, 32'h0);
			chk("buffer word", r, inv ? {16'h0, ~i[7:0], i[7:0]} : {16'h0, i[7:0], ~i[7:0]});
		end
	endtask : rb
	// Ending register image
	task regs(input logic [7:0] c, a0, a1, a2, h, e, s);
		rchk("count", `DWC_OFF_CNT, 32'hFF, {24'h0, c});
		rchk("addr0", `DWC_OFF_ADR0, 32'hFF, {24'h0, a0});
		rchk("addr1", `DWC_OFF_ADR1, 32'hFF, {24'h0, a1});
		rchk("addr2", `DWC_OFF_ADR2, 32'hFF, {24'h0, a2});
		rchk("head", `DWC_OFF_DEVH, 32'h0F, {24'h0, h});
		rchk("error", `DWC_OFF_ERR, 32'hFF, {24'h0, e});
		rchk("status", `DWC_OFF_STAT, 32'hC1, {24'h0, s});
	endtask : regs
	task stop_test;
		if (fail_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		unc_at = 16'hFFFF;
		crc_err = 1'b0;
		idnf_sel = 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		// Reset image, unmapped place
		rchk("devh reset", `DWC_OFF_DEVH, 32'hFF, 32'hA0);
		rchk("feature", `DWC_OFF_FEAT, 32'hFFFFFFFF, 32'h0);
		bus(1'b1, 8'h3C, 32'h55);
		rchk("unmapped", 8'h3C, 32'hFFFFFFFF, 32'h0);
		chk("okay", hresp, 32'h0);
		// PIO buffer load with the interrupt masked
		bus(1'b1, `DWC_OFF_CMD, `DWC_OP_WBUF);
		rchk("pio status", `DWC_OFF_STAT, 32'h88, 32'h08);
		for (i = 0; i < 256; i++) bus(1'b1, `DWC_OFF_DATA, {16'h0, ~i[7:0], i[7:0]});
		wait_irq();
		chk("irq masked", irq, 32'h0);
		rchk("pio end", `DWC_OFF_STAT, 32'hC1, 32'h40);
		rb(1'b1);
		bus(1'b1, `DWC_OFF_IRQ_EN, 32'h3);
		@(negedge mclk);
		chk("irq on", irq, 32'h1);
		bus(1'b1, `DWC_OFF_IRQ_CLR, 32'h3);
		@(negedge mclk);
		chk("irq off", irq, 32'h0);
		// DMA buffer load, only one interrupt
		bus(1'b1, `DWC_OFF_CMD, `DWC_OP_WBUF_DMA);
		wait_irq();
		chk("dma irq", irq, 32'h1);
		bus(1'b1, `DWC_OFF_IRQ_CLR, 32'h3);
		repeat (20) @(posedge mclk);
		rchk("no second irq", `DWC_OFF_IRQ_STS, 32'h3, 32'h0);
		rb(1'b0);
		// Media write, address mode, carry out of the low byte
		s0 = sect_cnt;
		bus(1'b1, `DWC_OFF_CNT, 32'h2);
		bus(1'b1, `DWC_OFF_ADR0, 32'hFF);
		bus(1'b1, `DWC_OFF_ADR1, 32'h1);
		bus(1'b1, `DWC_OFF_ADR2, 32'h0);
		bus(1'b1, `DWC_OFF_DEVH, 32'hE0);
		bus(1'b1, `DWC_OFF_CMD, `DWC_OP_WDMA);
		wait_irq();
		chk("sectors", sect_cnt - s0, 32'h2);
		chk("last addr", last_addr, {3'h0, 1'b1, 28'h0000200});
		chk("media data", bad_cnt, 32'h0);
		regs(8'h00, 8'h00, 8'h02, 8'h00, 8'h0, 8'h00, 8'h40);
		bus(1'b1, `DWC_OFF_IRQ_CLR, 32'h3);
		// Retry bit set, zero count, geometry mode, second sector fails
		s0 = sect_cnt;
		unc_at <= sect_cnt + 16'h1;
		bus(1'b1, `DWC_OFF_CNT, 32'h0);
		bus(1'b1, `DWC_OFF_ADR0, 32'h10);
		bus(1'b1, `DWC_OFF_ADR1, 32'h22);
		bus(1'b1, `DWC_OFF_ADR2, 32'h11);
		bus(1'b1, `DWC_OFF_DEVH, 32'hA3);
		bus(1'b1, `DWC_OFF_CMD, `DWC_OP_WDMA | 8'h01);
		wait_irq();
		chk("sectors", sect_cnt - s0, 32'h2);
		chk("last addr", last_addr, {3'h0, 1'b0, 28'h3112211});
		regs(8'hFF, 8'h11, 8'h22, 8'h11, 8'h3, 8'h04, 8'h41);
		rchk("fail event", `DWC_OFF_IRQ_STS, 32'h2, 32'h2);
		unc_at <= 16'hFFFF;
		bus(1'b1, `DWC_OFF_IRQ_CLR, 32'h3);
		// Unknown opcode is aborted
		bus(1'b1, `DWC_OFF_CMD, 32'h77);
		repeat (5) @(posedge mclk);
		rchk("abort", `DWC_OFF_ERR, 32'hFF, 32'h04);
		rchk("abort status", `DWC_OFF_STAT, 32'hC1, 32'h41);
		bus(1'b1, `DWC_OFF_IRQ_CLR, 32'h3);
		// Unknown address on the only sector: nothing written, address kept
		idnf_sel <= 1'b1;
		unc_at <= sect_cnt;
		bus(1'b1, `DWC_OFF_CNT, 32'h1);
		bus(1'b1, `DWC_OFF_ADR0, 32'h5);
		bus(1'b1, `DWC_OFF_ADR1, 32'h0);
		bus(1'b1, `DWC_OFF_ADR2, 32'h0);
		bus(1'b1, `DWC_OFF_DEVH, 32'hE0);
		bus(1'b1, `DWC_OFF_CMD, `DWC_OP_WDMA);
		wait_irq();
		regs(8'h01, 8'h05, 8'h00, 8'h00, 8'h0, 8'h10, 8'h41);
		idnf_sel <= 1'b0;
		unc_at <= 16'hFFFF;
		bus(1'b1, `DWC_OFF_IRQ_CLR, 32'h3);
		// Interface CRC fault in the first cycle of a DMA buffer load
		bus(1'b1, `DWC_OFF_CMD, `DWC_OP_WBUF_DMA);
		crc_err <= 1'b1;
		@(posedge mclk);
		crc_err <= 1'b0;
		wait_irq();
		rchk("crc error", `DWC_OFF_ERR, 32'hFF, 32'h80);
		rchk("crc status", `DWC_OFF_STAT, 32'hC1, 32'h41);
		rchk("crc event", `DWC_OFF_IRQ_STS, 32'h2, 32'h2);
		stop_test();
	end
endmodule : disk_write_command_handler_test
